// [src/dipk_packer.v]
// digital input image packer with register port and fault interrupt
//
// Operation
// - Image is built of whole words; module data start on byte boundaries.
// - Multi-byte values little-endian: low byte at the lower address.
// - Each input channel gives one bit showing its current signal state; acknowledge channels read 0 while their flag is latched.
// - Digital bytes follow all analog words in the image.
// - One-channel diagnostic module: state bit 0, diagnostic flag bit 1.
// - Plain two-channel module: channel 1 bit 0, channel 2 bit 1.
// - Two-channel diagnostic: states bits 0,1; diagnostic flags bits 2,3.
// - Diagnostic flag reports broken wire or short circuit on the channel.
// - Acknowledge module sets the channel flag when a fault arises.
// - Acknowledges come from output bits 2 and 3; bits 0,1 are zero.
// - Four-channel module: channels 1 to 4 in bits 0 to 3.
// - Eight-channel module: channels 1 to 8 in bits 0 to 7.
`timescale 1ns/1ps
`default_nettype none
`include "dipk_map.vh"

module dipk_packer #(
	parameter integer ANA_WORDS = 1
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset,
	// one-channel module with diagnostics
	input wire i_ch1d_state,
	input wire i_ch1d_fault,
	// plain two-channel module
	input wire [1:0] i_ch2_state,
	// two-channel module with diagnostics
	input wire [1:0] i_ch2d_state,
	input wire [1:0] i_ch2d_fault,
	// two-channel module with acknowledge
	input wire [1:0] i_ch2a_state,
	input wire [1:0] i_ch2a_fault,
	// four- and eight-channel modules
	input wire [3:0] i_ch4_state,
	input wire [7:0] i_ch8_state,
	// analog image words ahead of the digital data
	input wire [ANA_WORDS*16-1:0] i_analog_words,
	// register port
	input wire [`DIPK_ADDR_W-1:0] i_addr,
	input wire [`DIPK_DATA_W-1:0] i_wr_data,
	input wire i_wr,
	input wire i_rd,
	output reg [`DIPK_DATA_W-1:0] o_rd_data_q,
	// interrupt
	output wire o_irq
);

	localparam integer DIG_BASE_I = ANA_WORDS;
	localparam [`DIPK_ADDR_W-1:0] DIG_BASE = DIG_BASE_I[`DIPK_ADDR_W-1:0];

	reg [7:0] byte0_q;
	reg [7:0] byte1_q;
	reg [7:0] byte2_q;
	reg [7:0] byte4_q;
	reg [7:0] byte5_q;
	reg [1:0] ack_q;
	reg [`DIPK_EV_W-1:0] stat_q;
	reg [`DIPK_EV_W-1:0] stat_d;
	reg [`DIPK_EV_W-1:0] mask_q;
	reg [`DIPK_DATA_W-1:0] rd_d;
	wire [7:0] byte3;
	wire [1:0] ack_state;
	wire [1:0] ack_diag;
	wire [1:0] ack_set;
	wire [`DIPK_DIG_BYTES*8-1:0] dig_bytes;
	wire [`DIPK_EV_W-1:0] ev;
	wire wr_ack;
	wire wr_stat;
	wire wr_mask;
	integer i;

	assign wr_ack = i_wr & (i_addr == `DIPK_OUT_IMG);
	assign wr_stat = i_wr & (i_addr == `DIPK_IRQ_STAT);
	assign wr_mask = i_wr & (i_addr == `DIPK_IRQ_MASK);

	// acknowledge-capable channels
	dipk_ack_chan u_ack1 (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_state(i_ch2a_state[0]),
		.i_fault(i_ch2a_fault[0]),
		.i_ack(ack_q[0]),
		.o_state_q(ack_state[0]),
		.o_diag_q(ack_diag[0]),
		.o_set_q(ack_set[0])
	);

	dipk_ack_chan u_ack2 (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_state(i_ch2a_state[1]),
		.i_fault(i_ch2a_fault[1]),
		.i_ack(ack_q[1]),
		.o_state_q(ack_state[1]),
		.o_diag_q(ack_diag[1]),
		.o_set_q(ack_set[1])
	);

	// per-module image bytes, unused positions zero
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			byte0_q <= `DIPK_RST_BYTE;
			byte1_q <= `DIPK_RST_BYTE;
			byte2_q <= `DIPK_RST_BYTE;
			byte4_q <= `DIPK_RST_BYTE;
			byte5_q <= `DIPK_RST_BYTE;
		end else begin
			byte0_q <= {6'h00, i_ch1d_fault, i_ch1d_state};
			byte1_q <= {6'h00, i_ch2_state[1], i_ch2_state[0]};
			byte2_q <= {4'h0, i_ch2d_fault[1], i_ch2d_fault[0],
				i_ch2d_state[1], i_ch2d_state[0]};
			byte4_q <= {4'h0, i_ch4_state};
			byte5_q <= i_ch8_state;
		end
	end

	assign byte3 = {4'h0, ack_diag[1], ack_diag[0], ack_state[1], ack_state[0]};

	// byte n sits in word n/2, even n in the low half, odd n in the high half
	assign dig_bytes = {byte5_q, byte4_q, byte3, byte2_q, byte1_q, byte0_q};

	// acknowledge byte: only bits 2 and 3 are kept
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			ack_q <= `DIPK_RST_ACK;
		end else if (wr_ack) begin
			ack_q <= {i_wr_data[`DIPK_B_ACK2], i_wr_data[`DIPK_B_ACK1]};
		end
	end

	// rising diagnostic flags
	assign ev[`DIPK_EV_DIAG_1CH] = i_ch1d_fault & ~byte0_q[`DIPK_B_DIAG_1CH];
	assign ev[`DIPK_EV_DIAG_2D1] = i_ch2d_fault[0] & ~byte2_q[`DIPK_B_DIAG1];
	assign ev[`DIPK_EV_DIAG_2D2] = i_ch2d_fault[1] & ~byte2_q[`DIPK_B_DIAG2];
	assign ev[`DIPK_EV_DIAG_2A1] = ack_set[0];
	assign ev[`DIPK_EV_DIAG_2A2] = ack_set[1];

	// sticky status, write one to clear, a new event wins
	always @* begin
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_q & ~i_wr_data[`DIPK_EV_W-1:0];
		end
		stat_d = stat_d | ev;
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			stat_q <= `DIPK_RST_EV;
			mask_q <= `DIPK_RST_EV;
		end else begin
			stat_q <= stat_d;
			if (wr_mask) begin
				mask_q <= i_wr_data[`DIPK_EV_W-1:0];
			end
		end
	end

	assign o_irq = |(stat_q & mask_q);

	// read decode: analog words first, then the digital words
	always @* begin
		rd_d = `DIPK_RST_WORD;
		for (i = 0; i < ANA_WORDS; i = i + 1) begin
			if (i_addr == i[`DIPK_ADDR_W-1:0]) begin
				rd_d = i_analog_words[i*16 +: 16];
			end
		end
		for (i = 0; i < `DIPK_DIG_WORDS; i = i + 1) begin
			if (i_addr == DIG_BASE + i[`DIPK_ADDR_W-1:0]) begin
				rd_d = dig_bytes[i*16 +: 16];
			end
		end
		if (i_addr == `DIPK_OUT_IMG) begin
			rd_d = {12'h000, ack_q, 2'h0};
		end
		if (i_addr == `DIPK_IRQ_STAT) begin
			rd_d = {11'h000, stat_q};
		end
		if (i_addr == `DIPK_IRQ_MASK) begin
			rd_d = {11'h000, mask_q};
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_rd_data_q <= `DIPK_RST_WORD;
		end else if (i_rd) begin
			o_rd_data_q <= rd_d;
		end else begin
			o_rd_data_q <= `DIPK_RST_WORD;
		end
	end

endmodule

`default_nettype wire

// [inc/dipk_map.vh]
// register offsets, field positions and reset values of the input image packer
`ifndef DIPK_MAP_VH
`define DIPK_MAP_VH

// bus geometry
`define DIPK_ADDR_W 8
`define DIPK_DATA_W 16

// digital image: one byte per module, packed into words
`define DIPK_DIG_BYTES 6
`define DIPK_DIG_WORDS 3

// control and interrupt registers
`define DIPK_OUT_IMG 8'h40
`define DIPK_IRQ_STAT 8'h41
`define DIPK_IRQ_MASK 8'h42

// per-module bit positions
`define DIPK_B_STATE1 0
`define DIPK_B_STATE2 1
`define DIPK_B_DIAG_1CH 1
`define DIPK_B_DIAG1 2
`define DIPK_B_DIAG2 3
`define DIPK_B_ACK1 2
`define DIPK_B_ACK2 3

// interrupt status bits
`define DIPK_EV_DIAG_1CH 0
`define DIPK_EV_DIAG_2D1 1
`define DIPK_EV_DIAG_2D2 2
`define DIPK_EV_DIAG_2A1 3
`define DIPK_EV_DIAG_2A2 4
`define DIPK_EV_W 5

// reset values
`define DIPK_RST_BYTE 8'h00
`define DIPK_RST_WORD 16'h0000
`define DIPK_RST_ACK 2'h0
`define DIPK_RST_EV 5'h00

`endif

// [src/dipk_ack_chan.v]
// one acknowledge-capable input channel with latched fault flag
`timescale 1ns/1ps
`default_nettype none

module dipk_ack_chan (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset,
	// field side
	input wire i_state,
	input wire i_fault,
	// acknowledge from the output image
	input wire i_ack,
	// image side
	output reg o_state_q,
	output reg o_diag_q,
	output reg o_set_q
);

	wire diag_d;

	// fault sets the flag and wins over an acknowledge in the same cycle
	assign diag_d = i_fault | (o_diag_q & ~i_ack);

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_state_q <= 1'b0;
			o_diag_q <= 1'b0;
			o_set_q <= 1'b0;
		end else begin
			o_diag_q <= diag_d;
			o_set_q <= i_fault & ~o_diag_q;
			// input stays inactive while the flag is latched
			o_state_q <= i_state & ~diag_d;
		end
	end

endmodule

`default_nettype wire

// [sim/dipk_packer_properties.sv]
// port assertions for the input image packer
`timescale 1ns/1ps
`default_nettype none
module dipk_packer_properties #(parameter integer ANA_WORDS = 1) (
	input wire logic i_clk_sys, i_reset, i_ch1d_state, i_ch1d_fault, i_wr, i_rd, o_irq,
	input wire logic [1:0] i_ch2_state, i_ch2d_state, i_ch2d_fault, i_ch2a_state, i_ch2a_fault,
	input wire logic [3:0] i_ch4_state,
	input wire logic [7:0] i_ch8_state, i_addr,
	input wire logic [ANA_WORDS*16-1:0] i_analog_words,
	input wire logic [15:0] i_wr_data, o_rd_data_q
);
	localparam logic [7:0] W = ANA_WORDS;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	word_one_a: assert property (i_rd && i_addr == W |=> o_rd_data_q == {6'h00,
		$past(i_ch2_state, 2), 6'h00, $past(i_ch1d_fault, 2), $past(i_ch1d_state, 2)})
		else $error("one-channel or plain two-channel byte wrong");
	word_two_a: assert property (i_rd && i_addr == W + 8'h01 |=> o_rd_data_q[7:0] ==
		{4'h0, $past(i_ch2d_fault, 2), $past(i_ch2d_state, 2)}) else $error("diag byte wrong");
	word_three_a: assert property (i_rd && i_addr == W + 8'h02 |=> o_rd_data_q ==
		{$past(i_ch8_state, 2), 4'h0, $past(i_ch4_state, 2)}) else $error("wide modules wrong");
	fault_latch_a: assert property (i_rd && i_addr == W + 8'h01 && $past(i_ch2a_fault[0])
		|=> o_rd_data_q[10] && !o_rd_data_q[8]) else $error("ack channel fault not latched");
	unmapped_zero_a: assert property (i_rd && i_addr == 8'h80 |=> o_rd_data_q == 16'h0000)
		else $error("unmapped read not zero");
	idle_zero_a: assert property (!i_rd |=> o_rd_data_q == 16'h0000)
		else $error("read data outside its cycle");
	ack_low_a: assert property (i_rd && i_addr == 8'h40 |=> o_rd_data_q[1:0] == 2'b00 &&
		o_rd_data_q[15:4] == 12'h000) else $error("ack register spare bits set");
	reset_quiet_a: assert property (disable iff (1'b0) i_reset |=> !o_irq &&
		o_rd_data_q == 16'h0000) else $error("outputs not cleared by reset");
endmodule
bind dipk_packer dipk_packer_properties #(.ANA_WORDS(ANA_WORDS)) u_props (.*);
`default_nettype wire

// [sim/dipk_ctrl_model.sv]
// controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module dipk_ctrl_model (
	input wire logic i_clk_sys,
	output logic [7:0] o_addr,
	output logic [15:0] o_wd,
	output logic o_wr,
	output logic o_rd
);
	logic [15:0] q[$];
	initial begin
		o_addr = 8'h00;
		o_wd = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// one analog word sits ahead of the digital words
	function automatic logic [7:0] pos(input int n);
		return 8'h01 + n[7:0];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		o_addr <= a;
		o_wd <= d;
		o_wr <= 1'b1;
		@(posedge i_clk_sys);
		o_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		@(posedge i_clk_sys);
		o_addr <= a;
		o_rd <= 1'b1;
		q.push_back(x);
		@(posedge i_clk_sys);
		o_rd <= 1'b0;
	endtask
	task automatic ack(input logic [1:0] m);
		wr(8'h40, {12'h000, m, 2'b00});
	endtask
endmodule
`default_nettype wire

// [sim/test_digital_input_image_packer.sv]
// self-checking bench for the input image packer
`timescale 1ns/1ps
`default_nettype none
module test_digital_input_image_packer;
	logic i_clk_sys = 1'b0, i_reset = 1'b1, i_ch1d_state, i_ch1d_fault, pend = 1'b0;
	logic [1:0] i_ch2_state, i_ch2d_state, i_ch2d_fault, i_ch2a_state;
	logic [1:0] i_ch2a_fault;
	logic [3:0] i_ch4_state;
	logic [7:0] i_ch8_state;
	logic [15:0] i_analog_words;
	logic [31:0] r;
	wire logic [7:0] i_addr;
	wire logic [15:0] i_wr_data, o_rd_data_q;
	wire logic i_wr, i_rd, o_irq;
	int num_errors = 0, checks = 0;
	dipk_packer #(.ANA_WORDS(1)) dut (.*);
	dipk_ctrl_model ctl (.i_clk_sys, .o_addr(i_addr), .o_wd(i_wr_data), .o_wr(i_wr), .o_rd(i_rd));
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		checks++;
		if (s !== x) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial forever #50 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) pend <= i_rd;
	always @(negedge i_clk_sys) if (pend) chk(o_rd_data_q, ctl.q.pop_front());
	initial begin
		#1000000;
		num_errors++;
		conclude;
	end
	initial begin
		void'($urandom(32'h890c));
		{i_ch1d_state, i_ch1d_fault, i_ch2_state, i_ch2d_state, i_ch2d_fault} <= 8'h00;
		{i_ch2a_state, i_ch2a_fault, i_ch4_state, i_ch8_state, i_analog_words} <= 32'h0000_0000;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		ctl.rd(8'h41, 16'h0000);
		ctl.rd(8'h80, 16'h0000);
		repeat (20) begin
			@(posedge i_clk_sys);
			r = $urandom;
			{i_ch1d_state, i_ch1d_fault, i_ch2_state, i_ch2d_state, i_ch2d_fault} <= r[7:0];
			{i_ch2a_state, i_ch4_state, i_ch8_state} <= r[21:8];
			i_analog_words <= r[31:16];
			@(posedge i_clk_sys);
			ctl.rd(8'h00, i_analog_words);
			ctl.rd(ctl.pos(0), {6'h00, i_ch2_state, 6'h00, i_ch1d_fault, i_ch1d_state});
			ctl.rd(ctl.pos(1), {6'h00, i_ch2a_state, 4'h0, i_ch2d_fault, i_ch2d_state});
			ctl.rd(ctl.pos(2), {i_ch8_state, 4'h0, i_ch4_state});
		end
		@(posedge i_clk_sys);
		{i_ch1d_fault, i_ch2d_fault, i_ch2d_state} <= 5'h00;
		i_ch2a_state <= 2'b11;
		ctl.wr(8'h41, 16'h001f);
		ctl.wr(8'h42, 16'h0018);
		ctl.rd(8'h42, 16'h0018);
		@(negedge i_clk_sys);
		chk({15'h0000, o_irq}, 16'h0000);
		@(posedge i_clk_sys);
		i_ch2a_fault <= 2'b01;
		ctl.rd(ctl.pos(1), 16'h0600);
		i_ch2a_fault <= 2'b00;
		@(negedge i_clk_sys);
		chk({15'h0000, o_irq}, 16'h0001);
		ctl.rd(ctl.pos(1), 16'h0600);
		ctl.ack(2'b01);
		ctl.rd(ctl.pos(1), 16'h0300);
		ctl.rd(8'h40, 16'h0004);
		ctl.wr(8'h41, 16'h0008);
		@(negedge i_clk_sys);
		chk({15'h0000, o_irq}, 16'h0000);
		ctl.ack(2'b00);
		repeat (2) @(posedge i_clk_sys);
		conclude;
	end
endmodule
`default_nettype wire
